// [hdl/cgwp_defs.svh]
// Register offsets, bit positions, masks and reset values of the clock guard.
// Assumes an 8-bit register in the low lane of each 32-bit APB word.
`ifndef CGWP_DEFS_SVH
`define CGWP_DEFS_SVH

// Byte offsets on the APB
`define CGWP_OFF_PROT 8'h00
`define CGWP_OFF_PM2 8'h04
`define CGWP_OFF_CM0 8'h08
`define CGWP_OFF_CM1 8'h0C
`define CGWP_OFF_CM2 8'h10
`define CGWP_OFF_PLL 8'h14
`define CGWP_OFF_PCLK 8'h18
`define CGWP_OFF_PM0 8'h1C
`define CGWP_OFF_PD9 8'h20
`define CGWP_OFF_VOLTAGE_DET_CTRL2 8'h24

// Protect bits in write_protect_reg
`define CGWP_PRC_CLK 0
`define CGWP_PRC_PM 1
`define CGWP_PRC_PORT 2
`define CGWP_PRC_VOLT 3

// Bit positions in the clock registers
`define CGWP_PM2_LOCK 1
`define CGWP_CM0_WAITOFF 2
`define CGWP_CM0_MAINSTOP 5
`define CGWP_CM0_SUBSEL 7
`define CGWP_CM1_STOPMODE 0
`define CGWP_CM1_PLLSEL 1
`define CGWP_CM2_DETEN 0
`define CGWP_CM2_RINGSEL 1
`define CGWP_CM2_DETFLAG 2
`define CGWP_CM2_STOPPED 3
`define CGWP_CM2_ACTSEL 7
`define CGWP_PLL_EN 7

// Bits frozen by the clock lock, and software-writable bits of osc_detect_ctrl
`define CGWP_CM0_LOCKMASK 8'hA4
`define CGWP_CM1_LOCKMASK 8'h03
`define CGWP_CM2_LOCKMASK 8'h01
`define CGWP_PLL_LOCKMASK 8'hFF
`define CGWP_CM2_SWMASK 8'h83

// Reset values
`define CGWP_RST_PROT 4'h0
`define CGWP_RST_CM0 8'h00
`define CGWP_RST_CM1 8'h00
`define CGWP_RST_CM2 8'h00
`define CGWP_RST_PLL 8'h00
`define CGWP_RST_REG 8'h00

`endif

// [hdl/cgwp_pkg.sv]
// Types of the clock guard and write protect block.
// Used by the top module only; constants live in cgwp_defs.svh.
package cgwp_pkg;

  // CPU clock source, one-hot
  typedef enum logic [3:0] {
    CGWP_SRC_MAIN = 4'h1,
    CGWP_SRC_PLL = 4'h2,
    CGWP_SRC_RING = 4'h4,
    CGWP_SRC_SUB = 4'h8
  } cgwp_src_t;

endpackage

// [hdl/cgwp_sync2.sv]
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/10ps
module cgwp_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic meta_ff;

  // Only the second flop reads the first; reset to the running level of the
  // status pin, so the edge detector sees no false stop right after reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_ff <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule // cgwp_sync2

// [hdl/cgwp_osc_watch.sv]
// Turns the synchronised main-oscillator status into stop and restart pulses.
// Assumes runSync is already in the ref_clk domain.
`timescale 1ns/10ps
module cgwp_osc_watch (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Synchronised oscillator status
  input wire logic runSync,
  // One-cycle events
  output logic stopEvt,
  output logic reoscEvt
);
  logic run_ff;

  // Previous status; oscillator taken as running at reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_ff <= 1'b1;
    end else begin
      run_ff <= runSync;
    end
  end

  // Edge pulses
  assign stopEvt = run_ff & ~runSync;
  assign reoscEvt = ~run_ff & runSync;
endmodule // cgwp_osc_watch

// [hdl/cgwp_clock_guard.sv]
// Clock guard and write protect: clock lock, oscillation stop detection,
// protect register, all reached over an APB slave.
// Assumes one 100 MHz clock, synchronous reset and an asynchronous
// oscillator-status pin that is high while the main clock oscillates.
`timescale 1ns/10ps
`include "cgwp_defs.svh"
module cgwp_clock_guard
  import cgwp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator status pin and watchdog request
  input wire logic mainOscRun,
  input wire logic wdtIrq,
  // Interrupt and halt
  output logic detectIrq,
  output logic sharedVecIrq,
  output logic oscStopHalt,
  // Clock selection
  output logic [3:0] cpuClkSel,
  output logic periphOnRing,
  output logic ringOscRun,
  output logic waitPeriphOff,
  output logic mainClkStop,
  output logic stopModeReq,
  output logic pllEnable
);

  // Register state
  logic [3:0] protect_ff;
  logic [7:0] procMode2_ff;
  logic [7:0] clkCtrl0_ff;
  logic [7:0] clkCtrl1_ff;
  logic [7:0] detCtrl_ff;
  logic [7:0] pllCtrl_ff;
  logic [7:0] periphClk_ff;
  logic [7:0] procMode0_ff;
  logic [7:0] portDir9_ff;
  logic [7:0] voltDet2_ff;
  logic halt_ff;
  logic periphRing_ff;
  logic irq_ff;
  logic [31:0] rdata_ff;
  logic [7:0] nxt_detCtrl;
  logic [7:0] rdByte;
  logic rdHit;

  // Bus and event terms
  logic wrEn;
  logic locked;
  logic detEn;
  logic actIrq;
  logic flagSet;
  logic runSync;
  logic stopEvt;
  logic reoscEvt;
  logic stopHit;
  logic reoscHit;
  cgwp_src_t cpuSrc;

  // Oscillator status crosses in through two flops
  cgwp_sync2 u_sync (
    .clk(ref_clk),
    .rstn(rstn),
    .din(mainOscRun),
    .dout(runSync)
  );

  // Edge events on the main oscillator status
  cgwp_osc_watch u_watch (
    .clk(ref_clk),
    .rstn(rstn),
    .runSync(runSync),
    .stopEvt(stopEvt),
    .reoscEvt(reoscEvt)
  );

  // Write taken at the access edge, low byte lane only
  assign wrEn = psel & penable & pwrite & pstrb[0];
  assign locked = procMode2_ff[`CGWP_PM2_LOCK];
  assign detEn = detCtrl_ff[`CGWP_CM2_DETEN];
  assign actIrq = detCtrl_ff[`CGWP_CM2_ACTSEL];
  assign flagSet = detCtrl_ff[`CGWP_CM2_DETFLAG];

  // Events pass only while the detect flag is clear
  assign stopHit = stopEvt & detEn & actIrq & ~flagSet;
  assign reoscHit = reoscEvt & detEn & actIrq & ~flagSet;

  // CPU source from the selection bits
  always_comb begin
    if (clkCtrl0_ff[`CGWP_CM0_SUBSEL]) begin
      cpuSrc = CGWP_SRC_SUB;
    end else if (detCtrl_ff[`CGWP_CM2_RINGSEL]) begin
      cpuSrc = CGWP_SRC_RING;
    end else if (clkCtrl1_ff[`CGWP_CM1_PLLSEL]) begin
      cpuSrc = CGWP_SRC_PLL;
    end else begin
      cpuSrc = CGWP_SRC_MAIN;
    end
  end

  // Protect register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      protect_ff <= `CGWP_RST_PROT;
    end else if (wrEn && paddr == `CGWP_OFF_PROT) begin
      protect_ff <= pwdata[3:0];
    end else if (wrEn) begin
      protect_ff[`CGWP_PRC_PORT] <= 1'b0;
    end
  end

  // Mode group registers; the lock bit only ever sets
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      procMode2_ff <= `CGWP_RST_REG;
      procMode0_ff <= `CGWP_RST_REG;
    end else if (wrEn && protect_ff[`CGWP_PRC_PM]) begin
      if (paddr == `CGWP_OFF_PM2) begin
        procMode2_ff <= pwdata[7:0] | (procMode2_ff & 8'h02);
      end
      if (paddr == `CGWP_OFF_PM0) begin
        procMode0_ff <= pwdata[7:0];
      end
    end
  end

  // Clock control 0, 1 and PLL
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clkCtrl0_ff <= `CGWP_RST_CM0;
      clkCtrl1_ff <= `CGWP_RST_CM1;
      pllCtrl_ff <= `CGWP_RST_PLL;
      periphClk_ff <= `CGWP_RST_REG;
    end else if (wrEn && protect_ff[`CGWP_PRC_CLK]) begin
      if (paddr == `CGWP_OFF_CM0) begin
        clkCtrl0_ff <= locked ?
          ((clkCtrl0_ff & `CGWP_CM0_LOCKMASK) | (pwdata[7:0] & ~`CGWP_CM0_LOCKMASK)) :
          pwdata[7:0];
      end
      if (paddr == `CGWP_OFF_CM1) begin
        clkCtrl1_ff <= locked ?
          ((clkCtrl1_ff & `CGWP_CM1_LOCKMASK) | (pwdata[7:0] & ~`CGWP_CM1_LOCKMASK)) :
          pwdata[7:0];
      end
      if (paddr == `CGWP_OFF_PLL && !locked) begin
        pllCtrl_ff <= pwdata[7:0];
      end
      if (paddr == `CGWP_OFF_PCLK) begin
        periphClk_ff <= pwdata[7:0];
      end
    end
  end

  // Next value of osc_detect_ctrl: software first, hardware events win
  always_comb begin
    nxt_detCtrl = detCtrl_ff;
    if (wrEn && protect_ff[`CGWP_PRC_CLK] && paddr == `CGWP_OFF_CM2) begin
      nxt_detCtrl = (detCtrl_ff & ~`CGWP_CM2_SWMASK) | (pwdata[7:0] & `CGWP_CM2_SWMASK);
      if (locked) begin
        nxt_detCtrl[`CGWP_CM2_DETEN] = detCtrl_ff[`CGWP_CM2_DETEN];
      end
      // Software may only clear the detect flag
      nxt_detCtrl[`CGWP_CM2_DETFLAG] = flagSet & pwdata[`CGWP_CM2_DETFLAG];
    end
    if (stopHit) begin
      nxt_detCtrl[`CGWP_CM2_DETFLAG] = 1'b1;
      nxt_detCtrl[`CGWP_CM2_STOPPED] = 1'b1;
      if (cpuSrc == CGWP_SRC_MAIN) begin
        nxt_detCtrl[`CGWP_CM2_RINGSEL] = 1'b1;
      end
    end
    if (reoscHit) begin
      nxt_detCtrl[`CGWP_CM2_DETFLAG] = 1'b1;
      nxt_detCtrl[`CGWP_CM2_STOPPED] = 1'b0;
    end
  end

  // osc_detect_ctrl register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      detCtrl_ff <= `CGWP_RST_CM2;
    end else begin
      detCtrl_ff <= nxt_detCtrl;
    end
  end

  // Peripheral clocks on ring after a low speed stop
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      periphRing_ff <= 1'b0;
    end else if (stopHit && cpuSrc == CGWP_SRC_SUB) begin
      periphRing_ff <= 1'b1;
    end else if (runSync && wrEn && protect_ff[`CGWP_PRC_CLK] &&
                 paddr == `CGWP_OFF_CM2 && !pwdata[`CGWP_CM2_RINGSEL]) begin
      periphRing_ff <= 1'b0;
    end
  end

  // Detection interrupt pulse
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= stopHit | reoscHit;
    end
  end

  // Halt after a stop in reset mode; only rstn ends it
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      halt_ff <= 1'b0;
    end else if (stopEvt && detEn && !actIrq) begin
      halt_ff <= 1'b1;
    end
  end

  // Port and voltage group registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      portDir9_ff <= `CGWP_RST_REG;
      voltDet2_ff <= `CGWP_RST_REG;
    end else if (wrEn) begin
      if (paddr == `CGWP_OFF_PD9 && protect_ff[`CGWP_PRC_PORT]) begin
        portDir9_ff <= pwdata[7:0];
      end
      if (paddr == `CGWP_OFF_VOLTAGE_DET_CTRL2 && protect_ff[`CGWP_PRC_VOLT]) begin
        voltDet2_ff <= pwdata[7:0];
      end
    end
  end

  // Read decode
  always_comb begin
    rdHit = 1'b1;
    rdByte = 8'h00;
    unique case (paddr)
      `CGWP_OFF_PROT: rdByte = {4'h0, protect_ff};
      `CGWP_OFF_PM2: rdByte = procMode2_ff;
      `CGWP_OFF_CM0: rdByte = clkCtrl0_ff;
      `CGWP_OFF_CM1: rdByte = clkCtrl1_ff;
      `CGWP_OFF_CM2: rdByte = detCtrl_ff;
      `CGWP_OFF_PLL: rdByte = pllCtrl_ff;
      `CGWP_OFF_PCLK: rdByte = periphClk_ff;
      `CGWP_OFF_PM0: rdByte = procMode0_ff;
      `CGWP_OFF_PD9: rdByte = portDir9_ff;
      `CGWP_OFF_VOLTAGE_DET_CTRL2: rdByte = voltDet2_ff;
      default: rdHit = 1'b0;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rdata_ff <= {24'h00_0000, rdByte};
    end
  end

  // APB answer: no wait states, error on unmapped address
  assign prdata = rdata_ff;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~rdHit;

  // Outputs
  assign detectIrq = irq_ff;
  assign sharedVecIrq = irq_ff | wdtIrq;
  assign oscStopHalt = halt_ff;
  assign cpuClkSel = cpuSrc;
  assign periphOnRing = periphRing_ff | detCtrl_ff[`CGWP_CM2_RINGSEL];
  assign ringOscRun = periphOnRing;
  assign waitPeriphOff = clkCtrl0_ff[`CGWP_CM0_WAITOFF];
  assign mainClkStop = clkCtrl0_ff[`CGWP_CM0_MAINSTOP];
  assign stopModeReq = clkCtrl1_ff[`CGWP_CM1_STOPMODE];
  assign pllEnable = pllCtrl_ff[`CGWP_PLL_EN];

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_lock_cm0_bits: assert property (
    (locked && wrEn && paddr == `CGWP_OFF_CM0) |=>
      ((clkCtrl0_ff & `CGWP_CM0_LOCKMASK) ==
       ($past(clkCtrl0_ff) & `CGWP_CM0_LOCKMASK)))
    else $error("locked clock bits changed");

  a_halt_sticky: assert property (
    halt_ff |=> halt_ff [*8])
    else $error("halt released without reset");

  a_halt_cause: assert property (
    $rose(halt_ff) |-> $past(stopEvt && detEn && !actIrq))
    else $error("halt without stop in reset mode");

  a_stop_main_ring: assert property (
    (stopHit && cpuSrc == CGWP_SRC_MAIN) |=>
      (detectIrq && flagSet && detCtrl_ff[`CGWP_CM2_STOPPED] &&
       cpuClkSel == CGWP_SRC_RING && ringOscRun))
    else $error("main stop response wrong");

  a_stop_pll_keep: assert property (
    (stopHit && cpuSrc == CGWP_SRC_PLL && !wrEn) |=>
      (detectIrq && flagSet && $stable(detCtrl_ff[`CGWP_CM2_RINGSEL])))
    else $error("pll stop changed ring select");

  a_reosc_flags: assert property (
    (reoscHit && !wrEn) |=>
      (detectIrq && flagSet && !detCtrl_ff[`CGWP_CM2_STOPPED] &&
       $stable(detCtrl_ff[`CGWP_CM2_RINGSEL])))
    else $error("restart flags wrong");

  a_irq_blocked: assert property (
    detectIrq |-> (flagSet && !$past(flagSet)))
    else $error("interrupt while detect flag set");

  a_low_speed: assert property (
    (stopHit && cpuSrc == CGWP_SRC_SUB) |=>
      (cpuClkSel == CGWP_SRC_SUB && periphOnRing && ringOscRun ##1 periphOnRing))
    else $error("low speed stop response wrong");

  a_port_clear: assert property (
    (wrEn && protect_ff[`CGWP_PRC_PORT] && paddr != `CGWP_OFF_PROT) |=>
      (!protect_ff[`CGWP_PRC_PORT] &&
       protect_ff[`CGWP_PRC_CLK] == $past(protect_ff[`CGWP_PRC_CLK])))
    else $error("port protect bit not cleared");

  a_gate_clock: assert property (
    (wrEn && !protect_ff[`CGWP_PRC_CLK] && paddr == `CGWP_OFF_CM1) |=>
      $stable(clkCtrl1_ff))
    else $error("write passed closed clock gate");

  a_shared_vec: assert property (
    detectIrq |-> sharedVecIrq)
    else $error("detect request missing on shared vector");

endmodule // cgwp_clock_guard

// [tb/cgwp_osc_model.sv]
// Behavioural main oscillator seen through its status pin.
// Assumes the bench commands stops and restarts; slow lengthens settling.
`timescale 1ns/10ps
module cgwp_osc_model (
  // Commands from the bench
  input wire logic stopReq,
  input wire logic slow,
  // Oscillator status, high while running
  output logic mainOscRun
);
  initial mainOscRun = 1'b1;
  // Fast main clock
  // Status pin lags the command by a few ns or by several cycles
  always @(stopReq) mainOscRun <= #(slow ? 47 : 3) !stopReq;
endmodule // cgwp_osc_model

// [tb/tb_top.sv]
// Self-checking bench of the clock guard: register model, lock, detection.
// Assumes the oscillator model drives the status pin and APB has no waits.
`timescale 1ns/10ps
module tb_top;
  logic ref_clk, rstn, psel, penable, pwrite, wdtIrq, stopReq, slow, mainOscRun;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, rv;
  logic [3:0] pstrb, cpuClkSel;
  logic pready, pslverr, rerr, detectIrq, sharedVecIrq, oscStopHalt, periphOnRing;
  logic ringOscRun, waitPeriphOff, mainClkStop, stopModeReq, pllEnable;
  int mismatches, tests_run, i, lock, halt, lsl;
  int m[10];
  int offs[7] = '{0, 0, 8, 24, 28, 32, 36};

  cgwp_clock_guard dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mainOscRun(mainOscRun), .wdtIrq(wdtIrq),
    .detectIrq(detectIrq), .sharedVecIrq(sharedVecIrq), .oscStopHalt(oscStopHalt),
    .cpuClkSel(cpuClkSel), .periphOnRing(periphOnRing), .ringOscRun(ringOscRun),
    .waitPeriphOff(waitPeriphOff), .mainClkStop(mainClkStop), .stopModeReq(stopModeReq),
    .pllEnable(pllEnable));
  cgwp_osc_model osc_i (.stopReq(stopReq), .slow(slow), .mainOscRun(mainOscRun));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Model: expected CPU source, one-hot
  function automatic int src();
    if (m[2] & 8'h80) return 8;
    if (m[4] & 8'h02) return 4;
    if ((m[3] & 8'h02) && (m[5] & 8'h80)) return 2;
    return 1;
  endfunction

  // Model: register write with protect gates, clock lock and port-bit clear
  function automatic void mw(int a, int d);
    int k = a / 4;
    int g = (k == 1 || k == 7) ? m[0] & 2 : (k == 8) ? m[0] & 4 : (k == 9) ? m[0] & 8 : m[0] & 1;
    if (k == 0) m[0] = d & 15;
    else if (k > 9 || g == 0) g = 0;
    else if (k == 1) begin
      m[1] = d | (m[1] & 2);
      lock = (m[1] >> 1) & 1;
    end
    else if (k == 2) m[2] = lock ? (m[2] & 8'hA4) | (d & 8'h5B) : d;
    else if (k == 3) m[3] = lock ? (m[3] & 8'h03) | (d & 8'hFC) : d;
    else if (k == 4) begin
      if (!(d & 2)) lsl = 0;
      m[4] = (lock ? (m[4] & 1) | (d & 8'h82) : d & 8'h83) | (m[4] & 8'h08) | (m[4] & d & 4);
    end else if (k == 5) begin
      if (!lock) m[5] = d;
    end else m[k] = d;
    if (k != 0) m[0] &= 8'hB;
  endfunction

  // Model: stop or restart event, returns expected request count
  function automatic int mev(int stop);
    if (!(m[4] & 1) || (m[4] & 4)) return 0;
    if (!(m[4] & 8'h80)) begin
      halt |= stop;
      return 0;
    end
    if (stop) begin
      if (src() == 1) m[4] |= 2;
      if (src() == 8) lsl = 1;
      m[4] |= 8'h0C;
    end else m[4] = (m[4] | 4) & 8'hF7;
    return 1;
  endfunction

  // APB transfer: setup, then access held until pready
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    rv = $urandom();
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {rv[23:0], d};
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    mw(a, d);
  endtask

  task rchk(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), m[a / 4], rdat);
  endtask

  // Clock selection and register pins against the model, at a settled point
  task outs();
    @(negedge ref_clk);
    chk("cpuClkSel", src(), {28'h0, cpuClkSel});
    chk("periphOnRing", lsl | ((m[4] >> 1) & 1), {31'h0, periphOnRing});
    chk("ringOscRun", lsl | ((m[4] >> 1) & 1), {31'h0, ringOscRun});
    chk("waitPeriphOff", (m[2] >> 2) & 1, {31'h0, waitPeriphOff});
    chk("mainClkStop", (m[2] >> 5) & 1, {31'h0, mainClkStop});
    chk("stopModeReq", m[3] & 1, {31'h0, stopModeReq});
    chk("pllEnable", (m[5] >> 7) & 1, {31'h0, pllEnable});
  endtask

  // Oscillator stop or restart, counting detection pulses
  task osc(input logic s);
    int n, seen, e;
    e = mev(s);
    seen = 0;
    stopReq <= s;
    for (n = 0; n < 12; n++) begin
      @(posedge ref_clk);
      if (detectIrq === 1'b1) seen++;
    end
    chk("detectIrq", e, seen);
    outs();
  endtask

  task do_reset();
    stopReq <= 1'b0;
    rstn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    m = '{default: 0};
    lock = 0;
    halt = 0;
    lsl = 0;
  endtask

  initial begin
    {rstn, psel, penable, pwrite, wdtIrq, stopReq, slow} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    mismatches = 0;
    tests_run = 0;
    rv = $urandom(77637);
    do_reset();
    for (i = 0; i < 10; i++) rchk(8'(4 * i));
    wr(8'h30, 8'h5A);
    chk("unmapped pslverr", 1, {31'h0, rerr});
    for (i = 0; i < 40; i++) begin
      wr(8'(offs[$urandom_range(6, 0)]), 8'($urandom_range(255, 0)));
      rchk(8'h00);
    end
    for (i = 8; i < 40; i += 4) rchk(8'(i));
    outs();
    wr(8'h00, 8'h0F);
    wr(8'h24, 8'hA5);
    rchk(8'h24);
    rchk(8'h00);
    wr(8'h00, 8'h04);
    wr(8'h20, 8'h3C);
    wr(8'h20, 8'hC3);
    rchk(8'h20);
    // Interrupt mode, main source: stop, blocked events, restart
    do_reset();
    wr(8'h00, 8'h01);
    wr(8'h10, 8'h81);
    osc(1'b1);
    rchk(8'h10);
    slow <= 1'b1;
    osc(1'b0);
    osc(1'b1);
    wr(8'h10, 8'h83);
    osc(1'b0);
    rchk(8'h10);
    wr(8'h10, 8'h81);
    outs();
    @(posedge ref_clk);
    wdtIrq <= 1'b1;
    @(negedge ref_clk);
    chk("sharedVecIrq", 1, {31'h0, sharedVecIrq});
    @(posedge ref_clk);
    wdtIrq <= 1'b0;
    // PLL source keeps ring select
    do_reset();
    wr(8'h00, 8'h01);
    wr(8'h14, 8'h80);
    wr(8'h0C, 8'h02);
    wr(8'h10, 8'h81);
    osc(1'b1);
    rchk(8'h10);
    wr(8'h10, 8'h8F);
    outs();
    // Low speed mode: CPU stays on sub clock
    do_reset();
    slow <= 1'b0;
    wr(8'h00, 8'h01);
    wr(8'h08, 8'h80);
    wr(8'h10, 8'h81);
    osc(1'b1);
    // Detection disabled, then reset mode halts
    do_reset();
    wr(8'h00, 8'h01);
    osc(1'b1);
    osc(1'b0);
    wr(8'h10, 8'h01);
    osc(1'b1);
    chk("oscStopHalt", halt, {31'h0, oscStopHalt});
    do_reset();
    @(negedge ref_clk);
    chk("oscStopHalt", 0, {31'h0, oscStopHalt});
    // Clock lock armed, then partial writes
    // No wait request
    wr(8'h00, 8'h03);
    wr(8'h0C, 8'h01);
    wr(8'h04, 8'h02);
    wr(8'h00, 8'h01);
    rchk(8'h04);
    wr(8'h08, 8'hFF);
    rchk(8'h08);
    wr(8'h10, 8'h83);
    rchk(8'h10);
    wr(8'h14, 8'h80);
    rchk(8'h14);
    wr(8'h0C, 8'h00);
    rchk(8'h0C);
    outs();
    tally_and_finish();
  end
endmodule // tb_top
